//--- amf_map.vh
`ifndef AMF_MAP_VH
`define AMF_MAP_VH

// Conversion modes held in configuration bits 6 and 5.
`define AMF_MODE_ONE 2'h0
`define AMF_MODE_REP 2'h1
`define AMF_MODE_SWP 2'h2
`define AMF_MODE_RSW 2'h3

// Configuration register layout and reset value.
`define AMF_CFG_W 12
`define AMF_CFG_RST 12'h000
`define AMF_CFG_MODE_HI 6
`define AMF_CFG_MODE_LO 5
`define AMF_CFG_THR_HI 1
`define AMF_CFG_THR_LO 0
`define AMF_CFG_SEQ_HI 4
`define AMF_CFG_SEQ_LO 3
`define AMF_CFG_EOC 2
`define AMF_CFG_LONG 7
`define AMF_CFG_IREF 8

// Four-bit commands; a clear top bit means select channel.
`define AMF_CMD_RD_CFG 4'h9
`define AMF_CMD_WR_CFG 4'ha
`define AMF_CMD_RD_FIFO 4'he
`define AMF_CMD_NONE 4'hf
`define AMF_CMD_TOP 3

// Rising serial clock counts seen just before the event edge.
`define AMF_DEC_CNT 5'h03
`define AMF_WR_CNT 5'h0f
`define AMF_CONV_SHORT 5'h0f
`define AMF_CONV_LONG 5'h1b
`define AMF_CNT_MAX 5'h1f

// Result and buffer sizing.
`define AMF_RES_W 10
`define AMF_BUF_DEPTH 16
`define AMF_BUF_AW 4
`define AMF_CAP 5'h08
`define AMF_PAD_RES 6'h00
`define AMF_PAD_CFG 3'h0
`define AMF_PAD_LATE 5'h00

// Threshold levels by code, and the single-entry depth of one shot.
`define AMF_THR0 4'h8
`define AMF_THR1 4'h6
`define AMF_THR2 4'h4
`define AMF_THR3 4'h2
`define AMF_THR_ONE 4'h1

// Sweep tables, three bits per step, step 0 in the low bits.
`define AMF_SEQ0 24'hfac688
`define AMF_SEQ1 24'hd10d10
`define AMF_SEQ2 24'hda4480
`define AMF_SEQ3 24'h688688

`endif

//--- amf_fifo.v
`timescale 1ns/1ns
`include "amf_map.vh"
module amf_fifo #(
    parameter W = 10,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk, // System clock.
    input wire reset, // Asynchronous reset, active high.
    input wire clr, // Empties the buffer; a write in the same cycle still lands.
    input wire in_valid, // Write request.
    output wire in_ready, // Space available.
    input wire [W-1:0] in_data, // Write data.
    output wire out_valid, // Oldest entry present.
    input wire out_ready, // Removes the oldest entry.
    output wire [W-1:0] out_data, // Oldest entry.
    output wire [AW:0] count // Number of stored entries.
);
    reg [W-1:0] mem_r [0:DEPTH-1]; // Storage flip-flops.
    reg [AW-1:0] wr_ptr_r; // Next slot to write.
    reg [AW-1:0] rd_ptr_r; // Oldest slot.
    reg [AW:0] cnt_r; // Fill level.
    wire do_wr; // Accepted write.
    wire do_rd; // Accepted read.
    wire [AW-1:0] wr_slot; // Slot used by this write.

    assign in_ready = (cnt_r != DEPTH[AW:0]);
    assign out_valid = (cnt_r != {(AW+1){1'b0}});
    assign out_data = mem_r[rd_ptr_r];
    assign count = cnt_r;
    // A clear frees every slot, so the write is accepted then too.
    assign do_wr = in_valid & (in_ready | clr);
    assign do_rd = out_ready & out_valid & ~clr;
    assign wr_slot = clr ? {AW{1'b0}} : wr_ptr_r;

    // The data slot is written without reset; only pointers and the fill level need a value.
    always @(posedge clk)
    begin
        if (do_wr)
        begin
            mem_r[wr_slot] <= in_data;
        end
    end

    // Pointers and level move with writes, reads and clears.
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end
        else if (clr)
        begin
            // The optional write lands in slot zero.
            wr_ptr_r <= do_wr ? {{(AW-1){1'b0}}, 1'b1} : {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            cnt_r <= do_wr ? {{AW{1'b0}}, 1'b1} : {(AW+1){1'b0}};
        end
        else
        begin
            if (do_wr)
            begin
                wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
            end
            if (do_rd)
            begin
                rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
            end
            if (do_wr & ~do_rd)
            begin
                cnt_r <= cnt_r + {{AW{1'b0}}, 1'b1};
            end
            else if (do_rd & ~do_wr)
            begin
                cnt_r <= cnt_r - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule // amf_fifo

//--- amf_seq.v
`timescale 1ns/1ns
// Functional notes
// - Mode 10 converts sweep channels into FIFO.
// - Mode 10 sweep filling stops once threshold is met.
// - Threshold interrupt when stored count reaches threshold.
// - Mode 11 keeps converting past the threshold.
// - Mode 11 read after interrupt keeps results.
// - Mode 11 otherwise clears FIFO, then continues.
// - Bits 6 and 5 choose the mode.
// - Repeat mode clears FIFO when not read.
// - Trigger starts conversion while select is high.
// - End-of-conversion pin choice only in mode 00.
// - Trigger in FIFO modes needs internal reference.
// - Read configuration decoded, then shifted out.
// - Read configuration honoured only in mode 00.
// - First frame after interrupt outputs FIFO head.
// - Non-read command stops output, keeps head.
// - FIFO read never converts nor signals.
// - Configuration write loads twelve bits, no conversion.
// - Mode 00 trigger rising edge starts conversion.
// - Eight results held, threshold programmable.
// - Frame conversion after 16th or 28th edge.
// - Mode 00 uses a single result entry.
`include "amf_map.vh"
module amf_seq (
    input wire sys_clk, // System clock, 20 MHz.
    input wire reset, // Asynchronous reset, active high.
    input wire cs_n, // Chip select pin, active low.
    input wire frame_sync, // Frame sync pin, falling edge starts a frame.
    input wire sclk, // Serial clock pin from the host.
    input wire sdi, // Serial data in pin.
    input wire sample_trigger_n, // Sample trigger pin, active low.
    output wire serial_out, // Serial data out.
    output wire serial_out_en, // High while serial_out is driven.
    output wire int_eoc_n, // Interrupt, or end of conversion in mode 00.
    output wire conv_start, // One-cycle request to the converter core.
    output wire [2:0] conv_channel, // Channel for the requested conversion.
    input wire conv_done, // One-cycle result strobe from the core.
    input wire [`AMF_RES_W-1:0] conv_data, // Result that goes with conv_done.
    output wire [`AMF_CFG_W-1:0] config_out, // Configuration register contents.
    output wire [`AMF_BUF_AW:0] fifo_level // Stored result count.
);
    reg [4:0] s1_r; // First synchroniser stage.
    reg [4:0] s2_r; // Second synchroniser stage.
    reg [3:0] p_r; // Previous synchronised levels for edge finding.
    reg frame_act_r; // A serial frame is open.
    reg [4:0] bit_cnt_r; // Rising serial clocks seen in this frame.
    reg [10:0] rx_r; // Received bits, newest in bit 0.
    reg [3:0] cmd_r; // Command of the current frame.
    reg [`AMF_CFG_W-1:0] config_register_r; // Configuration register.
    reg [15:0] tx_r; // Output shifter, sent from the top.
    reg out_en_r; // Output driver enable.
    reg [2:0] chan_r; // Channel from the last select command.
    reg busy_r; // Conversion in progress.
    reg conv_start_r; // Conversion request pulse.
    reg [2:0] conv_chan_r; // Channel handed to the core.
    reg armed_r; // Mode 00 waits for a trigger rising edge.
    reg [2:0] sweep_idx_r; // Position in the sweep table.
    reg int_pend_r; // Threshold interrupt pending.
    reg first_r; // Next frame is the first after the interrupt.
    reg flush_pend_r; // Clear FIFO before the next store.
    reg done_flag_r; // Mode 00 conversion-done interrupt.
    reg pin_r; // Registered level of the shared pin.
    reg int_pend_nxt; // Next value of the interrupt flag.
    reg pin_nxt; // Next value of the shared pin.

    wire sclk_s = s2_r[0]; // Synchronised serial clock.
    wire cs_s = s2_r[1]; // Synchronised chip select.
    wire fs_s = s2_r[2]; // Synchronised frame sync.
    wire sdi_s = s2_r[3]; // Synchronised serial data.
    wire trig_s = s2_r[4]; // Synchronised sample trigger.
    wire sclk_rise = sclk_s & ~p_r[0]; // Serial clock rising edge.
    wire sclk_fall = ~sclk_s & p_r[0]; // Serial clock falling edge.
    wire cs_fall = ~cs_s & p_r[1]; // Select taken.
    wire cs_rise = cs_s & ~p_r[1]; // Select released.
    wire fs_fall = ~fs_s & p_r[2]; // Frame sync pulse.
    wire trig_fall = ~trig_s & p_r[3]; // Sampling begins.
    wire trig_rise = trig_s & ~p_r[3]; // Sampling ends.

    wire [1:0] mode = config_register_r[`AMF_CFG_MODE_HI:`AMF_CFG_MODE_LO]; // Mode.
    wire one_shot = (mode == `AMF_MODE_ONE); // Mode 00.
    wire fifo_mode = ~one_shot; // Modes 01, 10 and 11.
    wire sweep_on = mode[1]; // Modes 10 and 11 follow the sweep table.
    wire frame_start = cs_fall | (fs_fall & ~cs_s); // A new frame opens.
    wire frame_edge = frame_act_r & sclk_rise; // A bit arrives.
    wire dec = frame_edge & (bit_cnt_r == `AMF_DEC_CNT); // Fourth bit arrives.
    wire [3:0] cmd_now = {rx_r[2:0], sdi_s}; // Command at the fourth bit.
    wire cfg_wr = frame_edge & (cmd_r == `AMF_CMD_WR_CFG) & (bit_cnt_r == `AMF_WR_CNT);
    wire rd_fifo = dec & fifo_mode & (cmd_now == `AMF_CMD_RD_FIFO); // FIFO read.
    wire [3:0] thr = thr_of(config_register_r[`AMF_CFG_THR_HI:`AMF_CFG_THR_LO], one_shot);
    wire [`AMF_BUF_AW:0] cnt; // Stored entries.
    wire buf_ready; // Buffer has space.
    wire buf_valid; // Buffer holds a result.
    wire [`AMF_RES_W-1:0] head; // Oldest result.
    wire buf_pop; // Oldest result leaves.
    wire buf_clr; // Buffer is emptied.
    wire norm_hit; // Frame-triggered conversion point.
    wire ext_hit; // Trigger-started conversion point.
    wire room; // A new result may be stored.
    wire hold; // Sweep mode stopped at threshold.
    wire conv_go; // A conversion starts now.
    wire flush_set; // An event that demands a FIFO clear.

    // Threshold level by code; one shot always uses one entry.
    function [3:0] thr_of;
        input [1:0] code;
        input one;
        begin
            case (code)
                2'h0: thr_of = `AMF_THR0;
                2'h1: thr_of = `AMF_THR1;
                2'h2: thr_of = `AMF_THR2;
                default: thr_of = `AMF_THR3;
            endcase
            if (one)
            begin
                thr_of = `AMF_THR_ONE;
            end
        end
    endfunction

    // Channel at a given step of the chosen sweep table.
    function [2:0] seq_chan;
        input [1:0] sel;
        input [2:0] idx;
        reg [23:0] tbl;
        begin
            case (sel)
                2'h0: tbl = `AMF_SEQ0;
                2'h1: tbl = `AMF_SEQ1;
                2'h2: tbl = `AMF_SEQ2;
                default: tbl = `AMF_SEQ3;
            endcase
            seq_chan = tbl[idx*3 +: 3];
        end
    endfunction

    // Pins cross into the system clock through two flip-flops.
    always @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            s1_r <= 5'h16;
            s2_r <= 5'h16;
            p_r <= 4'he;
        end
        else
        begin
            s1_r <= {sample_trigger_n, sdi, frame_sync, cs_n, sclk};
            s2_r <= s1_r;
            p_r <= {s2_r[4], s2_r[2], s2_r[1], s2_r[0]};
        end
    end

    // Frame tracking, bit counting and command capture.
    always @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            frame_act_r <= 1'b0;
            bit_cnt_r <= 5'h00;
            rx_r <= 11'h000;
            cmd_r <= `AMF_CMD_NONE;
        end
        else if (frame_start)
        begin
            frame_act_r <= 1'b1;
            bit_cnt_r <= 5'h00;
            cmd_r <= `AMF_CMD_NONE;
        end
        else if (cs_rise)
        begin
            frame_act_r <= 1'b0;
        end
        else if (frame_edge)
        begin
            rx_r <= {rx_r[9:0], sdi_s};
            if (bit_cnt_r != `AMF_CNT_MAX)
            begin
                bit_cnt_r <= bit_cnt_r + 5'h01;
            end
            if (dec)
            begin
                cmd_r <= cmd_now;
            end
        end
    end

    always @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            config_register_r <= `AMF_CFG_RST;
        end
        else if (cfg_wr)
        begin
            config_register_r <= {rx_r, sdi_s};
        end
    end

    // Output shifter: loads a result or the configuration, then shifts.
    always @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            tx_r <= 16'h0000;
            out_en_r <= 1'b0;
        end
        else if (frame_start)
        begin
            out_en_r <= 1'b1;
            if (buf_valid & (one_shot | first_r))
            begin
                tx_r <= {head, `AMF_PAD_RES};
            end
            else
            begin
                tx_r <= 16'h0000;
            end
        end
        else if (cs_rise)
        begin
            out_en_r <= 1'b0;
        end
        else if (dec)
        begin
            // mode 00 only
            // A lead pad bit absorbs the fourth falling edge, so the MSB meets the fifth rise.
            if (one_shot & (cmd_now == `AMF_CMD_RD_CFG))
            begin
                tx_r <= {1'b0, config_register_r, `AMF_PAD_CFG};
            end
            else if (rd_fifo & ~first_r & buf_valid)
            begin
                tx_r <= {1'b0, head, `AMF_PAD_LATE};
            end
            else if (fifo_mode & first_r & ~rd_fifo)
            begin
                out_en_r <= 1'b0;
            end
        end
        else if (frame_act_r & sclk_fall)
        begin
            tx_r <= {tx_r[14:0], 1'b0};
        end
    end

    assign buf_pop = (frame_start & one_shot & buf_valid) | (rd_fifo & buf_valid);

    assign buf_clr = (conv_done & (flush_pend_r | one_shot)) | cfg_wr;

    assign norm_hit = frame_edge & ~cmd_r[`AMF_CMD_TOP] &
        (bit_cnt_r == (config_register_r[`AMF_CFG_LONG] ? `AMF_CONV_LONG : `AMF_CONV_SHORT));

    assign ext_hit = trig_rise & cs_s &
        (one_shot ? armed_r : config_register_r[`AMF_CFG_IREF]);

    assign room = buf_ready & ((cnt < `AMF_CAP) | flush_pend_r | one_shot);

    assign hold = (mode == `AMF_MODE_SWP) & int_pend_r;

    assign conv_go = (norm_hit | ext_hit) & ~busy_r & room & ~hold;

    assign flush_set = (dec & first_r & fifo_mode & (mode != `AMF_MODE_SWP) & ~rd_fifo) |
        (trig_fall & cs_s & (mode == `AMF_MODE_RSW) & int_pend_r);

    // Conversion requests, channel choice and busy tracking.
    always @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            conv_start_r <= 1'b0;
            conv_chan_r <= 3'h0;
            busy_r <= 1'b0;
        end
        else
        begin
            conv_start_r <= conv_go;
            if (conv_go)
            begin
                busy_r <= 1'b1;
                conv_chan_r <= sweep_on ?
                    seq_chan(config_register_r[`AMF_CFG_SEQ_HI:`AMF_CFG_SEQ_LO], sweep_idx_r) :
                    chan_r;
            end
            else if (conv_done)
            begin
                busy_r <= 1'b0;
            end
        end
    end

    // Select commands, the mode 00 trigger arm and the sweep position.
    always @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            chan_r <= 3'h0;
            armed_r <= 1'b0;
            sweep_idx_r <= 3'h0;
        end
        else
        begin
            if (dec & ~cmd_now[`AMF_CMD_TOP])
            begin
                chan_r <= cmd_now[2:0];
            end
            if (dec & one_shot & ~cmd_now[`AMF_CMD_TOP])
            begin
                armed_r <= 1'b1;
            end
            else if (trig_rise & cs_s)
            begin
                armed_r <= 1'b0;
            end
            if (cfg_wr | (hold & (cnt == {(`AMF_BUF_AW+1){1'b0}})))
            begin
                sweep_idx_r <= 3'h0;
            end
            else if (conv_go & sweep_on)
            begin
                sweep_idx_r <= sweep_idx_r + 3'h1;
            end
        end
    end

    // Threshold interrupt: held until the FIFO is emptied or cleared.
    always @*
    begin
        int_pend_nxt = fifo_mode & ~buf_clr & ((cnt >= {1'b0, thr}) |
            (int_pend_r & (cnt != {(`AMF_BUF_AW+1){1'b0}})));
    end

    // Interrupt bookkeeping; for first_r, flush_pend_r and done_flag_r a set in the clearing cycle wins.
    always @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            int_pend_r <= 1'b0;
            first_r <= 1'b0;
            flush_pend_r <= 1'b0;
            done_flag_r <= 1'b0;
        end
        else
        begin
            int_pend_r <= int_pend_nxt;
            first_r <= (int_pend_nxt & ~int_pend_r) | (first_r & ~dec);
            flush_pend_r <= flush_set | (flush_pend_r & ~conv_done);
            done_flag_r <= (conv_done & one_shot) | (done_flag_r & ~frame_start);
        end
    end

    // Shared pin level: end of conversion only where mode 00 allows it.
    always @*
    begin
        if (one_shot & config_register_r[`AMF_CFG_EOC])
        begin
            pin_nxt = ~busy_r;
        end
        else if (one_shot)
        begin
            pin_nxt = ~done_flag_r;
        end
        else
        begin
            pin_nxt = ~int_pend_r;
        end
    end

    // The shared pin is driven from a flip-flop.
    always @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            pin_r <= 1'b1;
        end
        else
        begin
            pin_r <= pin_nxt;
        end
    end

    // Result buffer; its ready stalls new conversions.
    amf_fifo #(
        .W(`AMF_RES_W),
        .DEPTH(`AMF_BUF_DEPTH),
        .AW(`AMF_BUF_AW)
    ) u_buf (
        .clk(sys_clk),
        .reset(reset),
        .clr(buf_clr),
        .in_valid(conv_done),
        .in_ready(buf_ready),
        .in_data(conv_data),
        .out_valid(buf_valid),
        .out_ready(buf_pop),
        .out_data(head),
        .count(cnt)
    );

    assign serial_out = tx_r[15];
    assign serial_out_en = out_en_r;
    assign int_eoc_n = pin_r;
    assign conv_start = conv_start_r;
    assign conv_channel = conv_chan_r;
    assign config_out = config_register_r;
    assign fifo_level = cnt;
endmodule // amf_seq

//--- amf_seq_asserts.sv
`timescale 1ns/1ns
`include "amf_map.vh"
// Watches the sequencer pins, the converter port and the result count.
module amf_seq_asserts (
    input wire sys_clk, // System clock.
    input wire reset, // Asynchronous reset, active high.
    input wire cs_n, // Chip select pin.
    input wire frame_sync, // Frame sync pin.
    input wire sclk, // Serial clock pin.
    input wire sdi, // Serial data in pin.
    input wire sample_trigger_n, // Sample trigger pin.
    input wire serial_out, // Serial data out.
    input wire serial_out_en, // Output enable.
    input wire int_eoc_n, // Interrupt or end of conversion.
    input wire conv_start, // Start request.
    input wire [2:0] conv_channel, // Requested channel.
    input wire conv_done, // Result strobe.
    input wire [`AMF_RES_W-1:0] conv_data, // Result.
    input wire [`AMF_CFG_W-1:0] config_out, // Configuration.
    input wire [`AMF_BUF_AW:0] fifo_level // Stored results.
);
    wire [1:0] mode = config_out[6:5]; // Programmed mode.
    wire [4:0] thr = 5'h08 - {2'h0, config_out[1:0], 1'b0}; // Threshold level.
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    start_pulse_a: assert property (conv_start |=> !conv_start)
        else $error("conv_start longer than one cycle");
    chan_hold_a: assert property (!conv_start |-> $stable(conv_channel))
        else $error("conv_channel moved without a start");
    fifo_cap_a: assert property (fifo_level <= 5'h08)
        else $error("more than eight results stored");
    one_depth_a: assert property (mode == 2'h0 && $past(mode) == 2'h0 |-> fifo_level <= 5'h01)
        else $error("one shot holds more than one result");
    level_step_a: assert property (fifo_level > $past(fifo_level) |->
        $past(conv_done) && fifo_level == $past(fifo_level) + 5'h01)
        else $error("fifo_level rose without one stored result");
    int_set_a: assert property (mode != 2'h0 && $stable(config_out) && fifo_level == thr
        && !conv_done |=> ($changed(config_out) or ##1 !int_eoc_n))
        else $error("no interrupt at threshold");
    int_clear_a: assert property (mode != 2'h0 && $stable(config_out) && fifo_level == 5'h00
        |=> ($changed(config_out) or ##1 int_eoc_n))
        else $error("interrupt with empty buffer");
    idle_quiet_a: assert property (cs_n [*6] |-> !serial_out_en)
        else $error("serial_out driven outside a frame");
    eoc_busy_a: assert property (mode == 2'h0 && config_out[2] && conv_start
        |-> ##[1:3] !int_eoc_n)
        else $error("no end of conversion low while converting");
    cover property (conv_start && mode == 2'h1);
    cover property (fifo_level == 5'h04 && mode == 2'h2);
    cover property (!int_eoc_n && mode != 2'h0);
endmodule // amf_seq_asserts

bind amf_seq amf_seq_asserts u_chk (.sys_clk(sys_clk), .reset(reset), .cs_n(cs_n),
    .frame_sync(frame_sync), .sclk(sclk), .sdi(sdi), .sample_trigger_n(sample_trigger_n),
    .serial_out(serial_out), .serial_out_en(serial_out_en), .int_eoc_n(int_eoc_n),
    .conv_start(conv_start), .conv_channel(conv_channel), .conv_done(conv_done),
    .conv_data(conv_data), .config_out(config_out), .fifo_level(fifo_level));

//--- amf_host.sv
`timescale 1ns/1ns
// Host serial port: drives the link pins just after the falling system clock edge.
module amf_host (
    input wire sys_clk, // System clock.
    input wire serial_out, // Data from the block.
    output logic cs_n, // Chip select, active low.
    output logic sclk, // Serial clock, idle low.
    output logic sdi // Serial data to the block.
);
    // Link pins idle: deselected, clock still.
    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end
    // Sends one 16 clock frame MSB first and samples the reply at each rising edge.
    // host framing
    task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
        rx = 16'h0000;
        cs_n = 1'b0;
        repeat (4) @(negedge sys_clk);
        for (int i = 15; i >= 0; i--)
        begin
            sdi = tx[i];
            repeat (4) @(negedge sys_clk);
            sclk = 1'b1;
            rx[i] = serial_out;
            repeat (4) @(negedge sys_clk);
            sclk = 1'b0;
        end
        repeat (4) @(negedge sys_clk);
        cs_n = 1'b1;
        // Released data line shows the inverse so stale bits are never mistaken.
        sdi = ~sdi;
        repeat (24) @(negedge sys_clk);
    endtask
endmodule // amf_host

//--- amf_seq_tb.sv
`timescale 1ns/1ns
`include "amf_map.vh"
`define CHK(what, exp, got) begin compares++; if ((got) !== (exp)) begin n_errors++; \
    $display("Error %s expected %0h seen %0h", what, exp, got); end end
// Bench: host model on the link, a small converter core, and the tests.
module amf_seq_tb;
    logic sys_clk = 1'b0; // System clock.
    logic reset = 1'b1; // Reset, held at start.
    logic trig_n = 1'b1; // Sample trigger, idle high.
    logic conv_done = 1'b0; // Core result strobe.
    logic [9:0] conv_data = 10'h3ff; // Core result.
    logic [2:0] ch; // Channel of the running conversion.
    logic [15:0] rx; // Bits seen in the last frame.
    int n_conv = 0; // Starts seen.
    int n_errors = 0; // Mismatches.
    int compares = 0; // Comparisons.
    wire cs_n, sclk, sdi, serial_out, serial_out_en, int_eoc_n, conv_start;
    wire [2:0] conv_channel;
    wire [11:0] config_out;
    wire [4:0] fifo_level;
    amf_seq u_dut (.sys_clk(sys_clk), .reset(reset), .cs_n(cs_n), .frame_sync(1'b1),
        .sclk(sclk), .sdi(sdi), .sample_trigger_n(trig_n), .serial_out(serial_out),
        .serial_out_en(serial_out_en), .int_eoc_n(int_eoc_n), .conv_start(conv_start),
        .conv_channel(conv_channel), .conv_done(conv_done), .conv_data(conv_data),
        .config_out(config_out), .fifo_level(fifo_level));
    amf_host u_host (.sys_clk(sys_clk), .serial_out(serial_out), .cs_n(cs_n), .sclk(sclk),
        .sdi(sdi));
    // Clock at 20 MHz.
    initial
    forever #25 sys_clk = ~sys_clk;
    // Converter core: answers each start after ten cycles with a channel-tagged result.
    initial
    forever
    begin
        @(negedge sys_clk);
        if (conv_start === 1'b1)
        begin
            n_conv++;
            ch = conv_channel;
            repeat (10) @(negedge sys_clk);
            conv_data = {ch, 7'h15};
            conv_done = 1'b1;
            @(negedge sys_clk);
            conv_done = 1'b0;
            conv_data = ~conv_data;
        end
    end
    // Prints the counts and the verdict, then stops.
    task print_verdict;
        $display("Counts: %0d compares, %0d mismatches", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Pulses the sample trigger while deselected and lets the conversion finish.
    task pulse_trig;
        trig_n = 1'b0;
        repeat (6) @(negedge sys_clk);
        trig_n = 1'b1;
        repeat (30) @(negedge sys_clk);
    endtask
    // Cuts a hung run short.
    initial
    begin
        #2000000;
        n_errors++;
        print_verdict();
    end
    // Main sequence.
    initial
    begin
        repeat (10) @(negedge sys_clk);
        reset = 1'b0;
        repeat (3) @(negedge sys_clk);
        `CHK("config_out", 12'h000, config_out)
        `CHK("int_eoc_n", 1'b1, int_eoc_n)
        `CHK("fifo_level", 5'h00, fifo_level)
        $display("Test reset done");
        u_host.frame({`AMF_CMD_WR_CFG, 12'h91c}, rx);
        `CHK("config_out", 12'h91c, config_out)
        `CHK("starts", 0, n_conv)
        u_host.frame({`AMF_CMD_RD_CFG, 12'h000}, rx);
        `CHK("config read", 12'h91c, rx[11:0])
        $display("Test config done");
        u_host.frame(16'h5000, rx);
        `CHK("starts", 1, n_conv)
        `CHK("fifo_level", 5'h01, fifo_level)
        u_host.frame(16'h3000, rx);
        `CHK("one shot result", {3'h5, 7'h15, 6'h00}, rx)
        $display("Test one shot done");
        u_host.frame({`AMF_CMD_WR_CFG, 12'h123}, rx);
        `CHK("fifo_level", 5'h00, fifo_level)
        u_host.frame(16'h1000, rx);
        pulse_trig();
        `CHK("fifo_level", 5'h02, fifo_level)
        `CHK("int_eoc_n", 1'b0, int_eoc_n)
        u_host.frame(16'h1000, rx);
        `CHK("fifo_level", 5'h01, fifo_level)
        `CHK("int_eoc_n", 1'b1, int_eoc_n)
        u_host.frame({`AMF_CMD_RD_CFG, 12'h000}, rx);
        `CHK("config read", 16'h0000, rx)
        $display("Test repeat done");
        u_host.frame({`AMF_CMD_WR_CFG, 12'h04a}, rx);
        pulse_trig();
        `CHK("starts", 5, n_conv)
        for (int i = 0; i < 5; i++)
            u_host.frame(16'h0000, rx);
        `CHK("fifo_level", 5'h04, fifo_level)
        `CHK("int_eoc_n", 1'b0, int_eoc_n)
        u_host.frame(16'h0000, rx);
        `CHK("fifo_level", 5'h04, fifo_level)
        for (int i = 0; i < 4; i++)
        begin
            u_host.frame({`AMF_CMD_RD_FIFO, 12'h000}, rx);
            `CHK("sweep result", {4'h0, 3'(i * 2), 7'h15, 2'h0}, rx)
        end
        `CHK("starts", 9, n_conv)
        `CHK("fifo_level", 5'h00, fifo_level)
        `CHK("int_eoc_n", 1'b1, int_eoc_n)
        $display("Test sweep done");
        u_host.frame({`AMF_CMD_WR_CFG, 12'h063}, rx);
        for (int i = 0; i < 3; i++)
            u_host.frame(16'h0000, rx);
        `CHK("fifo_level", 5'h01, fifo_level)
        `CHK("int_eoc_n", 1'b1, int_eoc_n)
        u_host.frame(16'h0000, rx);
        `CHK("int_eoc_n", 1'b0, int_eoc_n)
        u_host.frame({`AMF_CMD_RD_FIFO, 12'h000}, rx);
        `CHK("first result", {3'h2, 7'h15, 6'h00}, rx)
        u_host.frame({`AMF_CMD_RD_FIFO, 12'h000}, rx);
        `CHK("next result", {4'h0, 3'h3, 7'h15, 2'h0}, rx)
        `CHK("fifo_level", 5'h00, fifo_level)
        $display("Test repeat sweep done");
        print_verdict();
    end
endmodule // amf_seq_tb
